// ---- logic/asc_defs.svh ----
// Constants for the dual asynchronous serial channel block
// Assumes one system clock at 125 MHz and CPU I/O strobes on that clock
// What this block does
// - Transmit shifter sends its byte, then loads the waiting holding byte at once.
// - With nothing to send the transmit pin stays high.
// - Holding registers at 06H and 07H; writes accepted while the shifter is busy.
// - Holding register reads back and reading it leaves transmission untouched.
// - Each finished received character moves into a four-deep receive FIFO.
// - Read-only receive registers at 08H and 09H return the oldest character.
// - Receiver keeps shifting the next character even while the FIFO is full.
// - A character finishing while the shifter still holds one raises overrun.
// - Four-entry status FIFO beside data FIFO holds parity, framing, overrun, break.
// - Control register A at 00H: wake, rx, tx, bit4, addr/err-clear, three format bits.
// - Wake filter on in multidrop format: only addressing-bit-one characters update flags.
// - Outside multidrop format the wake filter enable does nothing.
// - Bit 6 enables the receiver.
// - Clearing bit 5 aborts transmission; the transmit-empty flag keeps its value.
// - Reset and I/O halt mode clear the receiver and transmitter enables.
// - Channel 0 bit 4 drives request-to-send directly with no side effects.
// - Shared pin carries request-to-send only while configuration bit 4 is zero.
// - Format bits pick 7/8 data, parity off/on, 1/2 stops, after a start bit.
// - Writing 0 to bit 3 clears errors; reading gives last addressing bit.
// - Channel 1 bit 4 selects transfer-end output when one; reset clears it.
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ADR_CA0 8'h00
`define ADR_CA1 8'h01
`define ADR_TH0 8'h06
`define ADR_TH1 8'h07
`define ADR_RX0 8'h08
`define ADR_RX1 8'h09
`define CA_WAKE 7
`define CA_RXEN 6
`define CA_TXON 5
`define CA_B4 4
`define CA_ERRCLR 3
`define CA_DW 2
`define CA_PAR 1
`define CA_STOP 0
`define CA_RST 8'h00
`define FIFO_DEPTH 3'h4
`define CLK_HZ 125000000
`define BAUD_RATE 115200
`define OVS 16
`define TICK_DIV (`CLK_HZ / (`OVS * `BAUD_RATE))
`define BIT_LAST 4'hf
`define BIT_MID 4'h7
`endif

// ---- logic/asc_pkg.sv ----
// Types shared by the serial channel modules
// Assumes asc_defs.svh for numeric constants
`default_nettype none
package asc_pkg;
	typedef struct packed {
		logic brk;
		logic ovr;
		logic fe;
		logic pe;
	} asc_stat_s;
	typedef struct packed {
		asc_stat_s st;
		logic [7:0] data;
	} asc_ent_s;
	typedef struct packed {
		logic mp;
		logic podd;
		logic dw8;
		logic par;
		logic stop2;
	} asc_fmt_s;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} asc_io_req_s;
	typedef enum logic [1:0] {
		ASC_RX_IDLE = 2'b00,
		ASC_RX_START = 2'b01,
		ASC_RX_DATA = 2'b10
	} asc_rx_state_e;
	// Bits after the start bit: data, parity or address bit, stops
	function automatic logic [3:0] asc_frame_bits(asc_fmt_s f);
		return 4'h7 + {3'h0, f.dw8} + {3'h0, f.mp | f.par} + {3'h0, f.stop2} + 4'h1;
	endfunction
	function automatic logic asc_parity(logic [7:0] d, logic podd);
		return (^d) ^ podd;
	endfunction
endpackage
`default_nettype wire

// ---- logic/asc_tx.sv ----
// Transmit shifter of one channel
// Assumes a 16x bit-rate tick and a holding register in the parent
`timescale 1ns/10ps
`default_nettype none
`include "asc_defs.svh"
module asc_tx (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic tick,
	input wire logic en,
	input wire asc_pkg::asc_fmt_s fmt,
	input wire logic mpbt,
	input wire logic ld_valid,
	input wire logic [7:0] ld_data,
	output logic ld_take,
	output logic txd
);
	import asc_pkg::*;
	logic busy_reg;
	logic [12:0] sh_reg;
	logic [3:0] left_reg;
	logic [3:0] sub_reg;
	logic [11:0] word;
	logic ebit;
	wire bit_end = busy_reg & tick & (sub_reg == `BIT_LAST);
	wire last_end = bit_end & (left_reg == 4'h0);
	assign ld_take = en & ld_valid & (~busy_reg | last_end);
	// Seven-bit frames take parity over the seven bits sent only
	assign ebit = fmt.mp ? mpbt : asc_parity(fmt.dw8 ? ld_data : {1'b0, ld_data[6:0]}, fmt.podd);
	always_comb begin
		word = 12'hfff;
		word[7:0] = fmt.dw8 ? ld_data : {1'b1, ld_data[6:0]};
		if (fmt.mp | fmt.par) begin
			word[fmt.dw8 ? 8 : 7] = ebit;
		end
	end
	assign txd = sh_reg[0];
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			busy_reg <= 1'b0;
			sh_reg <= 13'h1fff;
			left_reg <= 4'h0;
			sub_reg <= 4'h0;
		end else if (!en) begin
			busy_reg <= 1'b0;
			sh_reg <= 13'h1fff;
		end else if (ld_take) begin
			busy_reg <= 1'b1;
			sh_reg <= {word, 1'b0};
			left_reg <= asc_frame_bits(fmt);
			sub_reg <= 4'h0;
		end else if (last_end) begin
			busy_reg <= 1'b0;
			sh_reg <= 13'h1fff;
		end else if (busy_reg & tick) begin
			sub_reg <= sub_reg + 4'h1;
			if (bit_end) begin
				sh_reg <= {1'b1, sh_reg[12:1]};
				left_reg <= left_reg - 4'h1;
			end
		end
	end
endmodule // asc_tx
`default_nettype wire

// ---- logic/asc_rx.sv ----
// Receive shifter of one channel
// Assumes a synchronised receive line and a 16x bit-rate tick
`timescale 1ns/10ps
`default_nettype none
`include "asc_defs.svh"
module asc_rx (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic tick,
	input wire logic en,
	input wire asc_pkg::asc_fmt_s fmt,
	input wire logic rxd,
	output logic done,
	output asc_pkg::asc_ent_s ent,
	output logic addressing_bit
);
	import asc_pkg::*;
	asc_rx_state_e st_reg;
	logic [11:0] sh_reg;
	logic [3:0] idx_reg;
	logic [3:0] sub_reg;
	logic [11:0] s_now;
	logic [7:0] d;
	logic [3:0] sp;
	logic ebit;
	logic stop1;
	logic fe;
	wire samp = (st_reg == ASC_RX_DATA) & tick & (sub_reg == `BIT_LAST);
	wire last = samp & (idx_reg == asc_frame_bits(fmt) - 4'h1);
	assign s_now = sh_reg | (12'(rxd) << idx_reg);
	assign d = fmt.dw8 ? s_now[7:0] : {1'b0, s_now[6:0]};
	assign ebit = s_now[fmt.dw8 ? 8 : 7];
	assign sp = 4'h7 + {3'h0, fmt.dw8} + {3'h0, fmt.mp | fmt.par};
	assign stop1 = s_now[sp];
	assign fe = ~stop1 | (fmt.stop2 & ~s_now[sp + 4'h1]);
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= ASC_RX_IDLE;
			sh_reg <= 12'h000;
			idx_reg <= 4'h0;
			sub_reg <= 4'h0;
		end else if (!en) begin
			st_reg <= ASC_RX_IDLE;
		end else if (tick) begin
			sub_reg <= sub_reg + 4'h1;
			case (st_reg)
				ASC_RX_IDLE: begin
					sub_reg <= 4'h0;
					if (!rxd) begin
						st_reg <= ASC_RX_START;
					end
				end
				ASC_RX_START: begin
					if (sub_reg == `BIT_MID) begin
						st_reg <= rxd ? ASC_RX_IDLE : ASC_RX_DATA;
						sub_reg <= 4'h0;
						idx_reg <= 4'h0;
						sh_reg <= 12'h000;
					end
				end
				ASC_RX_DATA: begin
					if (samp) begin
						sh_reg <= s_now;
						idx_reg <= idx_reg + 4'h1;
						if (last) begin
							st_reg <= ASC_RX_IDLE;
						end
					end
				end
				default: st_reg <= ASC_RX_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			done <= 1'b0;
			ent <= '0;
			addressing_bit <= 1'b0;
		end else begin
			done <= en & last;
			if (en & last) begin
				ent.data <= d;
				ent.st.pe <= fmt.par & ~fmt.mp & (ebit != asc_parity(d, fmt.podd));
				ent.st.fe <= fe;
				ent.st.brk <= ~|d & ~stop1;
				ent.st.ovr <= 1'b0;
				addressing_bit <= fmt.mp & ebit;
			end
		end
	end
endmodule // asc_rx
`default_nettype wire

// ---- logic/asc_top.sv ----
// Two asynchronous serial channels with CPU I/O register access
// Assumes CPU strobes on clk_sys; serial receive pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "asc_defs.svh"
module asc_top (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire asc_pkg::asc_io_req_s io,
	output logic [7:0] io_rdata,
	input wire logic io_halt_mode,
	input wire logic sys_cfg_txs_sel,
	input wire logic csio_tx_data,
	input wire logic [1:0] multidrop_format,
	input wire logic [1:0] mpb_tx_value,
	input wire logic [1:0] parity_odd,
	input wire logic [1:0] serial_rx_pin,
	output logic [1:0] serial_tx_pin,
	output logic rts_txs_pin,
	output logic serial_clk_pin_disable,
	output logic [1:0] tx_empty_flag,
	output logic [1:0] rx_full_flag,
	output asc_pkg::asc_stat_s [1:0] rx_head_stat,
	output asc_pkg::asc_stat_s [1:0] err_flags
);
	import asc_pkg::*;

	// ****************************************
	// Decode and bit-rate tick
	// ****************************************
	logic [7:0] ctla_reg [2];
	logic [7:0] thr_reg [2];
	asc_ent_s fifo_reg [2][4];
	logic [1:0] wp_reg [2];
	logic [1:0] rp_reg [2];
	logic [2:0] cnt_reg [2];
	logic [1:0] pend_v_reg;
	asc_ent_s pend_reg [2];
	logic [1:0] mpb_last_reg;
	logic [1:0] rxs1_reg;
	logic [1:0] rxs2_reg;
	logic [6:0] tick_cnt_reg;
	logic tick;
	logic rts_pin_reg;
	logic [7:0] rdata_reg;
	logic [1:0] wr_ca;
	logic [1:0] wr_th;
	logic [1:0] rd_th;
	logic [1:0] rd_rx;
	logic [1:0] err_clr;
	logic [1:0] take;
	logic [1:0] rx_done;
	logic [1:0] rx_mpb;
	logic [1:0] acc;
	logic [1:0] push;
	logic [1:0] pop;
	logic [1:0] head_evt;
	asc_ent_s rx_ent [2];
	asc_stat_s head_next [2];
	asc_stat_s err_reg [2];
	asc_fmt_s fmt [2];

	assign wr_ca = {io.wr & (io.addr == `ADR_CA1), io.wr & (io.addr == `ADR_CA0)};
	assign wr_th = {io.wr & (io.addr == `ADR_TH1), io.wr & (io.addr == `ADR_TH0)};
	assign rd_th = {io.rd & (io.addr == `ADR_TH1), io.rd & (io.addr == `ADR_TH0)};
	assign rd_rx = {io.rd & (io.addr == `ADR_RX1), io.rd & (io.addr == `ADR_RX0)};
	assign tick = (tick_cnt_reg == 7'(`TICK_DIV - 1));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_reg <= 7'h00;
		end else begin
			tick_cnt_reg <= tick ? 7'h00 : tick_cnt_reg + 7'h01;
		end
	end

	// Two-stage synchroniser for the receive pins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rxs1_reg <= 2'h3;
			rxs2_reg <= 2'h3;
		end else begin
			rxs1_reg <= serial_rx_pin;
			rxs2_reg <= rxs1_reg;
		end
	end

	// ****************************************
	// Per-channel datapath
	// ****************************************
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		assign fmt[ch].mp = multidrop_format[ch];
		assign fmt[ch].podd = parity_odd[ch];
		assign fmt[ch].dw8 = ctla_reg[ch][`CA_DW];
		assign fmt[ch].par = ctla_reg[ch][`CA_PAR];
		assign fmt[ch].stop2 = ctla_reg[ch][`CA_STOP];
		assign err_clr[ch] = wr_ca[ch] & ~io.wdata[`CA_ERRCLR];
		// Wake filter only counts in multidrop format
		assign acc[ch] = rx_done[ch] & ~(fmt[ch].mp & ctla_reg[ch][`CA_WAKE] & ~rx_mpb[ch]);
		assign push[ch] = pend_v_reg[ch] & (cnt_reg[ch] != `FIFO_DEPTH);
		assign pop[ch] = rd_rx[ch] & (cnt_reg[ch] != 3'h0);
		assign head_evt[ch] = (push[ch] & (cnt_reg[ch] == 3'h0)) | (pop[ch] & (cnt_reg[ch] > 3'h1));
		assign head_next[ch] = (cnt_reg[ch] == 3'h0) ? pend_reg[ch].st : fifo_reg[ch][rp_reg[ch] + 2'h1].st;
		assign rx_full_flag[ch] = cnt_reg[ch] != 3'h0;
		assign rx_head_stat[ch] = rx_full_flag[ch] ? fifo_reg[ch][rp_reg[ch]].st : '0;
		assign err_flags[ch] = err_reg[ch];

		asc_tx u_tx (
			.clk_sys(clk_sys),
			.resetn(resetn),
			.tick(tick),
			.en(ctla_reg[ch][`CA_TXON]),
			.fmt(fmt[ch]),
			.mpbt(mpb_tx_value[ch]),
			.ld_valid(~tx_empty_flag[ch]),
			.ld_data(thr_reg[ch]),
			.ld_take(take[ch]),
			.txd(serial_tx_pin[ch])
		);

		asc_rx u_rx (
			.clk_sys(clk_sys),
			.resetn(resetn),
			.tick(tick),
			.en(ctla_reg[ch][`CA_RXEN]),
			.fmt(fmt[ch]),
			.rxd(rxs2_reg[ch]),
			.done(rx_done[ch]),
			.ent(rx_ent[ch]),
			.addressing_bit(rx_mpb[ch])
		);

		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				ctla_reg[ch] <= `CA_RST;
			end else begin
				if (wr_ca[ch]) begin
					ctla_reg[ch] <= io.wdata;
				end
				if (io_halt_mode) begin
					ctla_reg[ch][`CA_RXEN] <= 1'b0;
					ctla_reg[ch][`CA_TXON] <= 1'b0;
				end
			end
		end

		// Software write wins: the byte handed over is the old one
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				thr_reg[ch] <= 8'h00;
				tx_empty_flag[ch] <= 1'b1;
			end else if (wr_th[ch]) begin
				thr_reg[ch] <= io.wdata;
				tx_empty_flag[ch] <= 1'b0;
			end else if (take[ch]) begin
				tx_empty_flag[ch] <= 1'b1;
			end
		end

		// Pending slot models the shifter holding a character the FIFO could not take
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				pend_v_reg[ch] <= 1'b0;
				pend_reg[ch] <= '0;
				mpb_last_reg[ch] <= 1'b0;
			end else begin
				if (acc[ch]) begin
					mpb_last_reg[ch] <= rx_mpb[ch];
				end
				if (acc[ch] & pend_v_reg[ch] & ~push[ch]) begin
					pend_reg[ch].st.ovr <= 1'b1;
				end else if (acc[ch]) begin
					pend_v_reg[ch] <= 1'b1;
					pend_reg[ch] <= rx_ent[ch];
				end else if (push[ch]) begin
					pend_v_reg[ch] <= 1'b0;
				end
			end
		end

		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				wp_reg[ch] <= 2'h0;
				rp_reg[ch] <= 2'h0;
				cnt_reg[ch] <= 3'h0;
				for (int i = 0; i < 4; i++) begin
					fifo_reg[ch][i] <= '0;
				end
			end else begin
				if (push[ch]) begin
					fifo_reg[ch][wp_reg[ch]] <= pend_reg[ch];
					wp_reg[ch] <= wp_reg[ch] + 2'h1;
				end
				if (pop[ch]) begin
					rp_reg[ch] <= rp_reg[ch] + 2'h1;
				end
				cnt_reg[ch] <= cnt_reg[ch] + {2'h0, push[ch]} - {2'h0, pop[ch]};
			end
		end

		// Error flags latch as an entry becomes the oldest, except one pushed as the only entry pops; set beats clear
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				err_reg[ch] <= '0;
			end else begin
				err_reg[ch] <= (err_clr[ch] ? '0 : err_reg[ch]) | (head_evt[ch] ? head_next[ch] : '0);
			end
		end
	end

	// ****************************************
	// Read data and shared pins
	// ****************************************
	logic [7:0] rd_mux;
	logic [1:0] rd_ch;
	assign rd_ch = {1'b0, io.addr[0]};
	always_comb begin
		rd_mux = 8'h00;
		case (io.addr)
			`ADR_CA0, `ADR_CA1: begin
				rd_mux = ctla_reg[rd_ch[0]];
				rd_mux[`CA_ERRCLR] = fmt[rd_ch[0]].mp & mpb_last_reg[rd_ch[0]];
			end
			`ADR_TH0, `ADR_TH1: rd_mux = thr_reg[rd_ch[0]];
			`ADR_RX0, `ADR_RX1: rd_mux = rx_full_flag[rd_ch[0]] ? fifo_reg[rd_ch[0]][rp_reg[rd_ch[0]]].data : 8'h00;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= 8'h00;
			rts_pin_reg <= 1'b0;
		end else begin
			if (io.rd) begin
				rdata_reg <= rd_mux;
			end
			rts_pin_reg <= sys_cfg_txs_sel ? csio_tx_data : ctla_reg[0][`CA_B4];
		end
	end
	assign io_rdata = rdata_reg;
	assign rts_txs_pin = rts_pin_reg;
	assign serial_clk_pin_disable = ctla_reg[1][`CA_B4];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	property p_tx_abort;
		$fell(ctla_reg[0][`CA_TXON]) |-> ##1 serial_tx_pin[0];
	endproperty
	a_tx_abort: assert property (p_tx_abort) else $error("tx pin not idle after disable");
	property p_empty_held;
		!ctla_reg[0][`CA_TXON] && !wr_th[0] |=> $stable(tx_empty_flag[0]);
	endproperty
	a_empty_held: assert property (p_empty_held) else $error("tx empty moved while disabled");
	property p_thr_write;
		wr_th[0] |=> !tx_empty_flag[0] && thr_reg[0] == $past(io.wdata);
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("holding write lost");
	property p_thr_read;
		rd_th[0] && !wr_th[0] |=> io_rdata == $past(thr_reg[0]);
	endproperty
	a_thr_read: assert property (p_thr_read) else $error("holding readback wrong");
	property p_pop;
		pop[0] && !push[0] |=> cnt_reg[0] == $past(cnt_reg[0]) - 3'h1;
	endproperty
	a_pop: assert property (p_pop) else $error("fifo pop miscounted");
	property p_rx_data;
		pop[0] |=> io_rdata == $past(fifo_reg[0][rp_reg[0]].data);
	endproperty
	a_rx_data: assert property (p_rx_data) else $error("receive data not oldest");
	property p_halt;
		io_halt_mode |=> !ctla_reg[0][`CA_RXEN] && !ctla_reg[0][`CA_TXON] && !ctla_reg[1][`CA_TXON];
	endproperty
	a_halt: assert property (p_halt) else $error("halt left enables set");
	property p_rts;
		!sys_cfg_txs_sel && wr_ca[0] ##1 !sys_cfg_txs_sel |=> rts_txs_pin == $past(io.wdata[`CA_B4], 2);
	endproperty
	a_rts: assert property (p_rts) else $error("rts pin wrong");
	property p_ovr;
		acc[0] && pend_v_reg[0] && !push[0] |=> pend_reg[0].st.ovr && pend_v_reg[0];
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun not flagged");
	property p_depth;
		cnt_reg[0] <= `FIFO_DEPTH && (cnt_reg[0] == 3'h0) == !rx_full_flag[0];
	endproperty
	a_depth: assert property (p_depth) else $error("fifo depth broken");
	c_full: cover property (cnt_reg[0] == `FIFO_DEPTH);
	c_ovr: cover property (acc[0] && pend_v_reg[0] && !push[0]);
	c_handoff: cover property (take[0] && wr_th[0]);
	c_pop: cover property (pop[0] && push[0]);
endmodule // asc_top
`default_nettype wire

// ---- testbench/asc_remote.sv ----
// Remote asynchronous serial device facing the block
// Assumes idle-high lines and the block's fixed bit time
`timescale 1ns/10ps
`default_nettype none
`include "asc_defs.svh"
module asc_remote (
	input wire logic clk_sys,
	input wire logic line_in,
	output logic line_out
);
	localparam int BIT = `TICK_DIV * `OVS;
	logic [7:0] rx_q[$];
	logic [7:0] rx_d;
	initial line_out = 1'b1;
	// Start, seven data bits LSB first, optional address bit, one stop
	task automatic send_frame(input logic [6:0] d, input logic has_x, input logic xb);
		logic [9:0] bits;
		int n;
		bits = {1'b1, has_x ? xb : 1'b1, d, 1'b0};
		n = has_x ? 10 : 9;
		for (int i = 0; i < n; i++) begin
			line_out <= bits[i];
			repeat (BIT) @(posedge clk_sys);
		end
	endtask
	// Captures eight-bit frames, sampled mid-bit
	initial forever begin
		@(posedge clk_sys);
		if (line_in === 1'b0) begin
			repeat (BIT / 2) @(posedge clk_sys);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk_sys);
				rx_d[i] = line_in;
			end
			repeat (BIT) @(posedge clk_sys);
			rx_q.push_back(rx_d);
		end
	end
endmodule // asc_remote
`default_nettype wire

// ---- testbench/async_serial_channel_buffers_tb_top.sv ----
// Self-checking bench for the dual serial channel block
// Assumes the remote model on channel 0 transmit and channel 1 receive
`timescale 1ns/10ps
`default_nettype none
module async_serial_channel_buffers_tb_top;
	import asc_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	asc_io_req_s io = '0;
	logic [7:0] io_rdata;
	logic io_halt_mode = 1'b0;
	logic sys_cfg_txs_sel = 1'b0;
	logic csio_tx_data = 1'b0;
	logic [1:0] multidrop_format = 2'b00;
	logic [1:0] parity_odd = 2'b11;
	logic [1:0] serial_tx_pin;
	logic rts_txs_pin;
	logic serial_clk_pin_disable;
	logic [1:0] tx_empty_flag;
	logic [1:0] rx_full_flag;
	asc_stat_s [1:0] rx_head_stat;
	asc_stat_s [1:0] err_flags;
	logic rem_line;
	logic [7:0] rd;
	int fails = 0;
	int checked = 0;
	always #4 clk_sys = ~clk_sys;
	asc_top uut (.clk_sys(clk_sys), .resetn(resetn), .io(io), .io_rdata(io_rdata), .io_halt_mode(io_halt_mode),
		.sys_cfg_txs_sel(sys_cfg_txs_sel), .csio_tx_data(csio_tx_data), .multidrop_format(multidrop_format),
		.mpb_tx_value(2'b00), .parity_odd(parity_odd), .serial_rx_pin({rem_line, serial_tx_pin[1]}),
		.serial_tx_pin(serial_tx_pin),
		.rts_txs_pin(rts_txs_pin), .serial_clk_pin_disable(serial_clk_pin_disable), .tx_empty_flag(tx_empty_flag),
		.rx_full_flag(rx_full_flag), .rx_head_stat(rx_head_stat), .err_flags(err_flags));
	asc_remote rem (.clk_sys(clk_sys), .line_in(serial_tx_pin[0]), .line_out(rem_line));
	// ****************************************
	// Bus cycles and comparison
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		io <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		io <= '0;
	endtask
	task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		io <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		io <= '0;
		#1 d = io_rdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		io_rd(8'h00, rd); chk(rd, 8'h00);
		io_rd(8'h05, rd); chk(rd, 8'h00);
		io_rd(8'h08, rd); chk(rd, 8'h00);
		chk({6'h0, tx_empty_flag}, 8'h03);
		chk({6'h0, serial_tx_pin}, 8'h03);
		$display("test reset done");
	endtask
	task automatic t_ctrl;
		io_wr(8'h01, 8'h10); cyc(2);
		chk({7'h0, serial_clk_pin_disable}, 8'h01);
		io_rd(8'h01, rd); chk(rd, 8'h10);
		io_wr(8'h00, 8'h10); cyc(2);
		chk({7'h0, rts_txs_pin}, 8'h01);
		chk({6'h0, tx_empty_flag}, 8'h03);
		sys_cfg_txs_sel <= 1'b1; cyc(2);
		chk({7'h0, rts_txs_pin}, 8'h00);
		csio_tx_data <= 1'b1; cyc(2);
		chk({7'h0, rts_txs_pin}, 8'h01);
		sys_cfg_txs_sel <= 1'b0;
		io_wr(8'h00, 8'h70);
		io_halt_mode <= 1'b1; cyc(1);
		io_halt_mode <= 1'b0;
		io_rd(8'h00, rd); chk(rd, 8'h10);
		io_wr(8'h00, 8'h00);
		io_wr(8'h01, 8'h00);
		$display("test control done");
	endtask
	task automatic t_tx_fill;
		io_wr(8'h00, 8'h24);
		io_wr(8'h01, 8'h40);
		fork
			for (int i = 1; i <= 6; i++) rem.send_frame(7'(i * 17), 1'b0, 1'b0);
			begin
				io_wr(8'h06, 8'ha5); cyc(3);
				io_wr(8'h06, 8'h3c); cyc(1);
				chk({7'h0, tx_empty_flag[0]}, 8'h00);
				io_rd(8'h06, rd); chk(rd, 8'h3c);
				for (int i = 0; i < 25000 && rem.rx_q.size() < 2; i++) @(posedge clk_sys);
				chk(8'(rem.rx_q.size()), 8'h02);
				if (rem.rx_q.size() == 2) begin
					chk(rem.rx_q[0], 8'ha5);
					chk(rem.rx_q[1], 8'h3c);
				end
				cyc(1200);
				chk({7'h0, serial_tx_pin[0]}, 8'h01);
			end
		join
		cyc(4);
		chk({7'h0, rx_full_flag[1]}, 8'h01);
		for (int i = 1; i <= 4; i++) begin
			chk({4'h0, rx_head_stat[1]}, 8'h00);
			io_rd(8'h09, rd); chk(rd, 8'(i * 17));
			cyc(3);
		end
		chk({4'h0, rx_head_stat[1]}, 8'h04);
		chk({4'h0, err_flags[1]}, 8'h04);
		io_rd(8'h09, rd); chk(rd, 8'h55);
		cyc(3);
		chk({7'h0, rx_full_flag[1]}, 8'h00);
		io_wr(8'h01, 8'h40); cyc(2);
		chk({4'h0, err_flags[1]}, 8'h00);
		$display("test transmit and receive fill done");
	endtask
	task automatic t_wake;
		multidrop_format <= 2'b10;
		io_wr(8'h01, 8'hc0);
		rem.send_frame(7'h12, 1'b1, 1'b0);
		rem.send_frame(7'h34, 1'b1, 1'b1);
		cyc(4);
		io_rd(8'h09, rd); chk(rd, 8'h34);
		cyc(3);
		chk({7'h0, rx_full_flag[1]}, 8'h00);
		io_rd(8'h01, rd); chk(rd, 8'hc8);
		multidrop_format <= 2'b00;
		io_wr(8'h01, 8'h00);
		$display("test wake filter done");
	endtask
	// Channel 1 transmit loops back into channel 0 receive
	task automatic t_loop;
		io_wr(8'h00, 8'hc3);
		io_wr(8'h01, 8'h23);
		io_wr(8'h07, 8'h5a); cyc(12500);
		chk({7'h0, rx_full_flag[0]}, 8'h01);
		chk({4'h0, rx_head_stat[0]}, 8'h00);
		io_rd(8'h08, rd); chk(rd, 8'h5a);
		io_wr(8'h00, 8'h00);
		io_wr(8'h01, 8'h00);
		$display("test loopback done");
	endtask
	task automatic t_abort;
		io_wr(8'h01, 8'h20);
		io_wr(8'h07, 8'h00); cyc(3);
		io_wr(8'h07, 8'h55); cyc(2000);
		chk({7'h0, serial_tx_pin[1]}, 8'h00);
		io_wr(8'h01, 8'h00); cyc(2);
		chk({7'h0, serial_tx_pin[1]}, 8'h01);
		chk({7'h0, tx_empty_flag[1]}, 8'h00);
		cyc(1100);
		chk({7'h0, serial_tx_pin[1]}, 8'h01);
		$display("test abort done");
	endtask
	// ****************************************
	// Verdict and run control
	// ****************************************
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys);
		fails++;
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_tx_fill();
		t_wake();
		t_loop();
		t_abort();
		give_verdict();
	end
endmodule // async_serial_channel_buffers_tb_top
`default_nettype wire
